// ### include/sequencer_defines.vh
// Purpose: shared constants of the instruction cycle sequencer
// Assumes: included by its bare name from the logic files
// Notes:   definitions only
`ifndef SEQUENCER_DEFINES_VH
`define SEQUENCER_DEFINES_VH

// ----------------------------------------------------------------------
// program step codes (one nibble per step)
// ----------------------------------------------------------------------
`define OP_END        4'h0
`define OP_ALU        4'h1
`define OP_MRD        4'h2
`define OP_MWR        4'h3
`define OP_SIO        4'h4
`define OP_SRC        4'h5
`define OP_DST        4'h6
`define OP_OVX        4'h7
`define OP_MWE        4'h8
`define OP_SION       4'h9
`define OP_REP        4'hA

// ----------------------------------------------------------------------
// instruction classes
// ----------------------------------------------------------------------
`define CLS_ARITH     4'h0
`define CLS_COMPARE   4'h1
`define CLS_MOVE_WORD 4'h2
`define CLS_BRANCH_LINK 4'h3
`define CLS_BRANCH_WS 4'h4
`define CLS_DIVIDE    4'h5
`define CLS_SIGNED_DIVIDE 4'h6
`define CLS_IO_LOAD   4'h7
`define CLS_EXTERNAL  4'h8
`define CLS_LOAD_CTX  4'h9

// ----------------------------------------------------------------------
// addressing modes
// ----------------------------------------------------------------------
`define MODE_REG      2'b00
`define MODE_IND      2'b01
`define MODE_SYM_IDX  2'b10
`define MODE_AUTOINC  2'b11

// ----------------------------------------------------------------------
// timing counts and reset values
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define PROG_STEPS    5'd18
`define ALU_BLOCK_EXTRA 5'd13
`define SIO_FULL_EXTRA 5'd15
`define READY_RESET   1'b1

`endif

// ### logic/instruction_cycle_sequencer.v
// Purpose: orders the machine cycles of one instruction class
// Assumes: instruction class and mode fields stable while start is high
// Notes:   a load/context-switch sequence runs once after reset
//
// Function
// - add/subtract/byte/set ops: write at 6+src+dst
// - compares: two ALU cycles, writes only for autoincrement
// - word move: no destination read, write 5+src+dst
// - branch-link: two ALU, write at 5+src
// - workspace branch: ends at slot 12+src
// - divide: overflow stops at 10+src, else 16 ALU
// - signed divide clear overflow: last write 30+src
// - signed divide overflow: last write at 28+src
// - io load: C cycles, sixteen when C zero
// - external ops: three ALU then one I/O cycle
// - load/context switch: ten fixed cycles
// - ALU cycle two clocks, buses untouched
// - memory cycle two clocks plus wait states
// - I/O cycle: setup, then strobe, ready waits
// - derivation adds 0, 2 or 3 cycles
`timescale 1ns/10ps
`default_nettype none
`include "sequencer_defines.vh"

module instruction_cycle_sequencer (
   input  wire       clk,
   input  wire       resetn,
   input  wire       start,
   input  wire [3:0] instr_class,
   input  wire [1:0] src_mode,
   input  wire       src_reg_zero,
   input  wire [1:0] dst_mode,
   input  wire       dst_reg_zero,
   input  wire [3:0] io_count,
   input  wire       overflow_status_bit,
   input  wire       ready,
   output wire       busy,
   output wire       done,
   output wire       alu_cycle,
   output wire       mem_en,
   output wire       mem_we,
   output wire       sio_en,
   output wire       sio_clk,
   output wire [3:0] sio_bit
);

   // -------------------------------------------------------------------
   // program tables, step 0 in the low nibble
   // -------------------------------------------------------------------
   // class order
   function [71:0] prog;
      input [3:0] cls;
      begin
         case (cls)
            `CLS_ARITH:          prog = 72'h31262512;
            `CLS_COMPARE:        prog = 72'h11262512;
            `CLS_MOVE_WORD:      prog = 72'h3162512;
            `CLS_BRANCH_LINK:    prog = 72'h311512;
            `CLS_BRANCH_WS:      prog = 72'h1231313112512;
            `CLS_DIVIDE:         prog = 72'h3131171121122512;
            `CLS_SIGNED_DIVIDE:  prog = 72'h3181111A1121212512;
            `CLS_IO_LOAD:        prog = 72'h1912112512;
            `CLS_EXTERNAL:       prog = 72'h41112;
            `CLS_LOAD_CTX:       prog = 72'h1231313121;
            default:             prog = 72'h0;
         endcase
      end
   endfunction

   function [3:0] seq_op;
      input [3:0] cls;
      input [4:0] step;
      reg   [71:0] pg;
      begin
         pg = prog(cls);
         seq_op = (step >= `PROG_STEPS) ? `OP_END : pg[{step, 2'b00} +: 4];
      end
   endfunction

   // derivation sub-sequence for one operand
   function [3:0] deriv_op;
      input [1:0] mode;
      input       reg_zero;
      input [1:0] idx;
      reg   [11:0] sub;
      begin
         case (mode)
            `MODE_IND:     sub = 12'h012;
            `MODE_AUTOINC: sub = 12'h312;
            `MODE_SYM_IDX: sub = reg_zero ? 12'h121 : 12'h122;
            default:       sub = 12'h000;
         endcase
         deriv_op = (idx == 2'd3) ? `OP_END : sub[{idx, 2'b00} +: 4];
      end
   endfunction

   // -------------------------------------------------------------------
   // ready pin synchroniser
   // -------------------------------------------------------------------
   reg ready_s1_r;
   reg ready_s2_r;
   reg ready_s3_r;
   reg ready_r;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ready_s1_r <= `READY_RESET;
         ready_s2_r <= `READY_RESET;
         ready_s3_r <= `READY_RESET;
         ready_r    <= `READY_RESET;
      end else begin
         ready_s1_r <= ready;
         ready_s2_r <= ready_s1_r;
         ready_s3_r <= ready_s2_r;
         if (ready_s2_r == ready_s3_r) begin
            ready_r <= ready_s2_r;
         end
      end
   end

   // -------------------------------------------------------------------
   // sequencing state
   // -------------------------------------------------------------------
   reg       busy_r;
   reg       boot_r;
   reg       done_r;
   reg       phase_r;
   reg [3:0] cls_r;
   reg [4:0] pc_r;
   reg [1:0] sub_r;
   reg [1:0] sidx_r;
   reg [4:0] rep_r;
   reg [3:0] kind_r;
   reg       endaft_r;
   reg [3:0] sio_bit_r;
   reg [1:0] smode_r;
   reg       szero_r;
   reg [1:0] dmode_r;
   reg       dzero_r;
   reg [3:0] cnt_r;
   reg       busy_nxt;
   reg       done_nxt;
   reg [3:0] cls_nxt;
   reg [4:0] pc_nxt;
   reg [1:0] sub_nxt;
   reg [1:0] sidx_nxt;
   reg [4:0] rep_nxt;
   reg [3:0] kind_nxt;
   reg       endaft_nxt;
   reg       launch;
   reg [4:0] p;
   reg [3:0] op;
   reg [3:0] d;
   wire is_alu = (kind_r == `OP_ALU);
   wire is_mem = (kind_r == `OP_MRD) | (kind_r == `OP_MWR);
   wire is_sio = (kind_r == `OP_SIO);
   // ALU cycle ends on second clock regardless of ready
   // memory cycle holds its second clock while ready is low
   // I/O cycle also waits on ready in its second clock
   wire cyc_last = busy_r & phase_r & (is_alu | ready_r);

   always @* begin
      busy_nxt   = busy_r;
      done_nxt   = 1'b0;
      cls_nxt    = cls_r;
      pc_nxt     = pc_r;
      sub_nxt    = sub_r;
      sidx_nxt   = sidx_r;
      rep_nxt    = rep_r;
      kind_nxt   = kind_r;
      endaft_nxt = endaft_r;
      launch     = 1'b0;
      p          = 5'h00;
      op         = `OP_END;
      d          = `OP_END;
      if (!busy_r) begin
         if (boot_r | start) begin
            busy_nxt   = 1'b1;
            cls_nxt    = boot_r ? `CLS_LOAD_CTX : instr_class;
            sub_nxt    = 2'd0;
            rep_nxt    = 5'd0;
            endaft_nxt = 1'b0;
            launch     = 1'b1;
         end
      end else if (cyc_last) begin
         if (endaft_r) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end else if (rep_r != 5'd0) begin
            rep_nxt = rep_r - 5'd1;
         end else begin
            if (sub_r == 2'd1) begin
               d = deriv_op(smode_r, szero_r, sidx_r + 2'd1);
            end else if (sub_r == 2'd2) begin
               d = deriv_op(dmode_r, dzero_r, sidx_r + 2'd1);
            end
            if (d != `OP_END) begin
               sidx_nxt = sidx_r + 2'd1;
               kind_nxt = d;
            end else begin
               sub_nxt = 2'd0;
               launch  = 1'b1;
               p       = pc_r + 5'd1;
            end
         end
      end
      if (launch) begin
         op = seq_op(cls_nxt, p);
         if ((op == `OP_SRC) | (op == `OP_DST)) begin
            // direct register mode adds no cycles
            d = (op == `OP_SRC) ? deriv_op(smode_r, szero_r, 2'd0) :
                                  deriv_op(dmode_r, dzero_r, 2'd0);
            if (d != `OP_END) begin
               // later slots wait until derivation ends
               sub_nxt  = (op == `OP_SRC) ? 2'd1 : 2'd2;
               sidx_nxt = 2'd0;
               kind_nxt = d;
            end else begin
               p  = p + 5'd1;
               op = seq_op(cls_nxt, p);
            end
         end
         pc_nxt = p;
         case (op)
            `OP_ALU, `OP_MRD, `OP_MWR, `OP_SIO: begin
               kind_nxt = op;
            end
            `OP_OVX: begin
               // overflow set ends after this ALU cycle
               kind_nxt   = `OP_ALU;
               endaft_nxt = overflow_status_bit;
               rep_nxt    = overflow_status_bit ? 5'd0 : `ALU_BLOCK_EXTRA;
            end
            `OP_REP: begin
               kind_nxt = `OP_ALU;
               rep_nxt  = `ALU_BLOCK_EXTRA;
            end
            `OP_MWE: begin
               // overflow set makes this the last write
               kind_nxt   = `OP_MWR;
               endaft_nxt = overflow_status_bit;
            end
            `OP_SION: begin
               kind_nxt = `OP_SIO;
               rep_nxt  = (cnt_r == 4'h0) ? `SIO_FULL_EXTRA :
                          {1'b0, cnt_r - 4'h1};
            end
            `OP_END: begin
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
            end
            default: ;
         endcase
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busy_r    <= 1'b0;
         boot_r    <= 1'b1;
         done_r    <= 1'b0;
         phase_r   <= 1'b0;
         cls_r     <= `CLS_ARITH;
         pc_r      <= 5'h00;
         sub_r     <= 2'd0;
         sidx_r    <= 2'd0;
         rep_r     <= 5'd0;
         kind_r    <= `OP_END;
         endaft_r  <= 1'b0;
         sio_bit_r <= 4'h0;
         smode_r   <= `MODE_REG;
         szero_r   <= 1'b0;
         dmode_r   <= `MODE_REG;
         dzero_r   <= 1'b0;
         cnt_r     <= 4'h0;
      end else begin
         busy_r   <= busy_nxt;
         done_r   <= done_nxt;
         cls_r    <= cls_nxt;
         pc_r     <= pc_nxt;
         sub_r    <= sub_nxt;
         sidx_r   <= sidx_nxt;
         rep_r    <= rep_nxt;
         kind_r   <= busy_nxt ? kind_nxt : `OP_END;
         endaft_r <= endaft_nxt;
         if (!busy_r) begin
            phase_r   <= 1'b0;
            sio_bit_r <= 4'h0;
            if (boot_r) begin
               boot_r <= 1'b0;
            end else if (start) begin
               // operand fields latched so they may change afterwards
               smode_r <= src_mode;
               szero_r <= src_reg_zero;
               dmode_r <= dst_mode;
               dzero_r <= dst_reg_zero;
               cnt_r   <= io_count;
            end
         end else begin
            if (!phase_r) begin
               phase_r <= 1'b1;
            end else if (cyc_last) begin
               phase_r <= 1'b0;
            end
            // bit address advances after each I/O cycle
            if (cyc_last & is_sio) begin
               sio_bit_r <= sio_bit_r + 4'h1;
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign busy      = busy_r;
   assign done      = done_r;
   assign alu_cycle = busy_r & is_alu;
   assign mem_en    = busy_r & is_mem;
   assign mem_we    = busy_r & (kind_r == `OP_MWR);
   assign sio_en    = busy_r & is_sio;
   // strobe only in the second clock once ready is seen
   assign sio_clk   = busy_r & is_sio & phase_r & ready_r;
   assign sio_bit   = sio_bit_r;

endmodule

`default_nettype wire

// ### testbench/sequencer_chk.sv
// Purpose: port timing checks of the cycle sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound onto every sequencer instance
`timescale 1ns/10ps
`default_nettype none
module sequencer_chk (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       start,
   input wire logic       busy,
   input wire logic       done,
   input wire logic       alu_cycle,
   input wire logic       mem_en,
   input wire logic       mem_we,
   input wire logic       sio_en,
   input wire logic       sio_clk,
   input wire logic [3:0] sio_bit
);
   logic [6:0] alu_run_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // consecutive alu clocks, must pair up into two-clock cycles
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         alu_run_r <= 7'h00;
      else
         alu_run_r <= alu_cycle ? alu_run_r + 7'h01 : 7'h00;
   end
   property p_alu_quiet; alu_cycle |-> !mem_en && !sio_en && !sio_clk;
   endproperty
   a_alu_quiet: assert property (p_alu_quiet)
      else $error("bus active in alu cycle");
   property p_alu_even; $fell(alu_cycle) |-> !alu_run_r[0]; endproperty
   a_alu_even: assert property (p_alu_even)
      else $error("odd alu clock count");
   property p_mem_two; $rose(mem_en) |=> mem_en; endproperty
   a_mem_two: assert property (p_mem_two)
      else $error("memory cycle under two clocks");
   property p_we_mem; mem_we |-> mem_en; endproperty
   a_we_mem: assert property (p_we_mem)
      else $error("write outside memory cycle");
   property p_sio_setup; $rose(sio_en) |-> !sio_clk ##1 sio_en; endproperty
   a_sio_setup: assert property (p_sio_setup)
      else $error("io strobe in setup clock");
   property p_sio_clk; sio_clk |-> sio_en && $past(sio_en); endproperty
   a_sio_clk: assert property (p_sio_clk)
      else $error("io strobe outside second clock");
   property p_sio_step; $fell(sio_clk) |-> sio_bit == $past(sio_bit) + 4'h1;
   endproperty
   a_sio_step: assert property (p_sio_step)
      else $error("bit index did not step");
   // an unknown class started in the done cycle ends at once, so a
   // second done pulse is legal only right after such a start
   property p_done_one; done |-> !busy ##1 (!done || $past(start));
   endproperty
   a_done_one: assert property (p_done_one)
      else $error("done not a single pulse");
   property p_idle_quiet; !busy |-> !alu_cycle && !mem_en && !sio_en;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("cycle while idle");
endmodule
bind instruction_cycle_sequencer sequencer_chk u_sequencer_chk (
   .clk(clk), .resetn(resetn), .start(start), .busy(busy), .done(done),
   .alu_cycle(alu_cycle), .mem_en(mem_en), .mem_we(mem_we),
   .sio_en(sio_en), .sio_clk(sio_clk), .sio_bit(sio_bit));
`default_nettype wire

// ### testbench/mem_io_partner.sv
// Purpose: memory and io devices answering with ready
// Assumes: ready sampled through the sequencer's synchroniser
// Notes:   stall mode drops ready 3 clocks in every 8
`timescale 1ns/10ps
`default_nettype none
module mem_io_partner (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic stall_en,
   output var  logic ready
);
   logic [2:0] phase_r;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= 3'h0;
         ready   <= 1'b1;
      end else begin
         phase_r <= phase_r + 3'h1;
         ready   <= !(stall_en && phase_r < 3'h3);
      end
   end
endmodule
`default_nettype wire

// ### testbench/tb_instruction_cycle_sequencer.sv
// Purpose: compares cycle traces with a model of every class
// Assumes: one machine cycle is two clocks while ready holds
// Notes:   under stalls runs of like cycles are compared merged
`timescale 1ns/10ps
`default_nettype none
`include "sequencer_defines.vh"
module tb_instruction_cycle_sequencer;
   localparam logic [2:0] alu_c = 3'h1, rd_c = 3'h2, wr_c = 3'h3, io_c = 3'h4;
   logic       clk = 1'b0, resetn = 1'b0, start = 1'b0, stall_en = 1'b0;
   logic [3:0] instr_class = 4'h0, io_count = 4'h0, c;
   logic [1:0] src_mode = 2'b00, dst_mode = 2'b00;
   logic       src_reg_zero = 1'b0, dst_reg_zero = 1'b0;
   logic       overflow_status_bit = 1'b0;
   wire logic  ready, busy, done, alu_cycle, mem_en, mem_we, sio_en, sio_clk;
   wire logic [3:0] sio_bit;
   int         error_cnt = 0, checks = 0, seed = 66723, n_sio, n_clk = 0, t;
   logic [2:0] exp_q[$], obs_q[$];

   instruction_cycle_sequencer u_instruction_cycle_sequencer (.clk(clk),
      .resetn(resetn), .start(start), .instr_class(instr_class),
      .src_mode(src_mode), .src_reg_zero(src_reg_zero), .dst_mode(dst_mode),
      .dst_reg_zero(dst_reg_zero), .io_count(io_count),
      .overflow_status_bit(overflow_status_bit), .ready(ready), .busy(busy),
      .done(done), .alu_cycle(alu_cycle), .mem_en(mem_en), .mem_we(mem_we),
      .sio_en(sio_en), .sio_clk(sio_clk), .sio_bit(sio_bit));
   mem_io_partner u_mem_io_partner (.clk(clk), .resetn(resetn),
      .stall_en(stall_en), .ready(ready));

   always #50 clk = ~clk;
   always @(negedge clk) begin
      if (busy === 1'b1)
         obs_q.push_back(alu_cycle === 1'b1 ? alu_c : sio_en === 1'b1 ? io_c
            : mem_en !== 1'b1 ? 3'h0 : mem_we === 1'b1 ? wr_c : rd_c);
      if (sio_clk === 1'b1)
         n_clk++;
   end

   task automatic check(input string what, input int e, input logic [7:0] g);
      checks++;
      if (g !== 8'(e)) begin
         error_cnt++;
         $display("[FAIL] %s expected %0d seen %0d", what, e, g);
      end
   endtask
   task automatic put(input logic [2:0] k, input int n = 1);
      repeat (n) exp_q.push_back(k);
      if (k == io_c) n_sio += n;
   endtask
   task automatic deriv(input logic [1:0] m, input logic z);
      case (m)
         2'b01: begin put(rd_c); put(alu_c); end
         2'b11: begin put(rd_c); put(alu_c); put(wr_c); end
         2'b10: begin put(z ? alu_c : rd_c); put(rd_c); put(alu_c); end
         default: ;
      endcase
   endtask
   task automatic expect_seq(input logic [3:0] k);
      exp_q.delete();
      n_sio = 0;
      if (k < 4'h8) begin
         put(rd_c); put(alu_c); deriv(src_mode, src_reg_zero);
      end
      case (k)
         `CLS_ARITH, `CLS_COMPARE, `CLS_MOVE_WORD: begin
            put(rd_c);
            deriv(dst_mode, dst_reg_zero);
            if (k != `CLS_MOVE_WORD) put(rd_c);
            put(alu_c);
            put(k == `CLS_COMPARE ? alu_c : wr_c);
         end
         `CLS_BRANCH_LINK: begin put(alu_c, 2); put(wr_c); end
         `CLS_BRANCH_WS: begin
            put(rd_c); put(alu_c, 2);
            repeat (2) begin put(wr_c); put(alu_c); end
            put(wr_c); put(rd_c); put(alu_c);
         end
         `CLS_DIVIDE: begin
            put(rd_c, 2); put(alu_c, 2); put(rd_c); put(alu_c, 2);
            if (overflow_status_bit) put(alu_c);
            else begin put(alu_c, 16); put(wr_c); put(alu_c); put(wr_c); end
         end
         `CLS_SIGNED_DIVIDE: begin
            repeat (2) begin put(rd_c); put(alu_c); end
            put(rd_c); put(alu_c, 20); put(wr_c);
            if (!overflow_status_bit) begin put(alu_c); put(wr_c); end
         end
         `CLS_IO_LOAD: begin
            put(rd_c); put(alu_c, 2); put(rd_c); put(alu_c);
            put(io_c, io_count == 4'h0 ? 16 : io_count); put(alu_c);
         end
         `CLS_EXTERNAL: begin put(rd_c); put(alu_c, 3); put(io_c); end
         `CLS_LOAD_CTX: begin
            put(alu_c); put(rd_c);
            repeat (3) begin put(alu_c); put(wr_c); end
            put(rd_c); put(alu_c);
         end
         default: ;
      endcase
   endtask
   task automatic wait_done();
      for (int k = 0; k < 400 && done !== 1'b1; k++) @(posedge clk) #1;
      check("done", 1, {7'h00, done});
   endtask
   task automatic finish_one(input string what);
      logic [2:0] a[$], b[$];
      foreach (obs_q[i])
         if (!stall_en || i == 0 || obs_q[i] != obs_q[i-1]) a.push_back(obs_q[i]);
      foreach (exp_q[i]) begin
         if (!stall_en) b.push_back(exp_q[i]);
         if (!stall_en || i == 0 || exp_q[i] != exp_q[i-1]) b.push_back(exp_q[i]);
      end
      check({what, " length"}, b.size(), 8'(a.size()));
      foreach (b[i]) if (i < a.size()) check(what, b[i], 8'(a[i]));
      check({what, " bit index"}, n_sio % 16, {4'h0, sio_bit});
      check({what, " strobes"}, n_sio, 8'(n_clk));
      obs_q.delete();
      n_clk = 0;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #3000000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge clk);
      #1;
      expect_seq(`CLS_LOAD_CTX);
      resetn = 1'b1;
      wait_done();
      finish_one("boot");
      // back to back: each start is raised in the done cycle
      for (t = 0; t < 60; t++) begin
         stall_en = t >= 48;
         c = t < 22 ? 4'(t % 11) : 4'($unsigned($random(seed)) % 11);
         {src_reg_zero, dst_reg_zero, src_mode, dst_mode, io_count} =
            10'($random(seed));
         overflow_status_bit = 1'(t < 22 ? t / 11 : $random(seed));
         if (t == 7) io_count = 4'h0;
         instr_class = c;
         expect_seq(c);
         start = 1'b1;
         @(posedge clk) #1;
         start = 1'b0;
         wait_done();
         finish_one("trace");
         $display("test %0d class %0d ended", t, c);
      end
      conclude();
   end
endmodule
`default_nettype wire
